/* File: bench/pda_alarm_tb_top.sv */
// self-checking testbench of the process/deviation alarm
`timescale 1ns/1ps
`default_nettype none

module pda_alarm_tb_top;
    localparam int DW = 18;
    logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0, prdata, rd;
    logic          pready, pslverr, err, alarm_out, alarm_out_error, attention, error_seen;
    logic          mon_err, mute, ack, dis;
    logic [DW-1:0] want_value = '0, want_center = '0, monitored_value, center_value;
    logic [3:0]    flags = 4'h0;
    int            failures = 0, tests_run = 0, cycles = 0;

    always #50 pclk = ~pclk;

    // ten-cycle second keeps delay tests short
    pda_alarm #(.DW(DW), .HW(14), .TICK_CYCLES(10)) pda_alarm_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .monitored_value(monitored_value), .monitored_error(mon_err),
        .center_value(center_value), .mute_request(mute), .acknowledge_reset(ack), .disable_request(dis),
        .alarm_out(alarm_out), .alarm_out_error(alarm_out_error), .attention(attention));
    pda_source #(.DW(DW)) pda_source_inst (.pclk(pclk), .presetn(presetn), .want_value(want_value),
        .want_center(want_center), .want_flags(flags), .alarm_out_error(alarm_out_error),
        .monitored_value(monitored_value), .center_value(center_value), .monitored_error(mon_err),
        .mute_request(mute), .acknowledge_reset(ack), .disable_request(dis), .error_seen(error_seen));

    // ----------------
    // shared tasks
    // ----------------
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic oc(input logic exp);
        chk("alarm_out", alarm_out, exp);
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input int d);
        apb(a, 1'b1, d);
    endtask

    task automatic val(input int v, input int n);
        want_value <= v[DW-1:0];
        repeat (n) @(posedge pclk);
    endtask

    task automatic pulse(input logic [3:0] f);
        flags <= f;
        repeat (2) @(posedge pclk);
        flags <= 4'h0;
        repeat (4) @(posedge pclk);
    endtask

    function automatic int cfg(input int t, s, l, si, b, d, g);
        return t | (s << 2) | (l << 4) | (si << 5) | (b << 6) | (d << 8) | (g << 9);
    endfunction

    // ----------------
    // scenarios
    // ----------------
    task automatic t_regs;
        apb(pda_pkg::OFF_CTRL, 1'b0, 32'h0);
        chk("ctrl", rd, 32'h0);
        wr(pda_pkg::OFF_HYST, 0);
        apb(pda_pkg::OFF_HYST, 1'b0, 32'h0);
        chk("hyst", rd, 32'h1);
        apb(8'h1c, 1'b0, 32'h0);
        chk("pslverr", err, 1);
    endtask

    task automatic t_proc;
        wr(pda_pkg::OFF_HIGH_SP, 100);
        wr(pda_pkg::OFF_LOW_SP, -100);
        wr(pda_pkg::OFF_HYST, 10);
        wr(pda_pkg::OFF_CTRL, cfg(1, 0, 0, 0, 0, 1, 0));
        val(101, 4);
        oc(1'b1);
        chk("attention", attention, 1);
        val(95, 4);
        oc(1'b1);
        val(90, 4);
        oc(1'b0);
        val(-101, 4);
        oc(1'b1);
        wr(pda_pkg::OFF_CTRL, cfg(1, 0, 0, 0, 0, 0, 1));
        val(-101, 4);
        oc(1'b0);
        chk("attention", attention, 0);
        val(0, 4);
        oc(1'b1);
        wr(pda_pkg::OFF_CTRL, cfg(1, 1, 0, 0, 0, 0, 0));
        val(-200, 4);
        oc(1'b0);
        wr(pda_pkg::OFF_CTRL, cfg(1, 2, 0, 0, 0, 0, 0));
        val(200, 4);
        oc(1'b0);
        val(-200, 4);
        oc(1'b1);
        val(0, 4);
    endtask

    task automatic t_latch;
        wr(pda_pkg::OFF_CTRL, cfg(1, 0, 1, 0, 0, 0, 0));
        val(200, 4);
        val(0, 4);
        oc(1'b1);
        wr(pda_pkg::OFF_CMD, 1 << pda_pkg::C_RESTART);
        val(0, 3);
        oc(1'b0);
        val(200, 1);
        wr(pda_pkg::OFF_CMD, 1 << pda_pkg::C_CLEAR);
        val(200, 3);
        oc(1'b1);
        val(0, 4);
        wr(pda_pkg::OFF_CMD, 1 << pda_pkg::C_CLEAR);
        val(0, 3);
        oc(1'b0);
        val(200, 4);
        val(0, 2);
        pulse(4'b0010);
        oc(1'b0);
    endtask

    task automatic t_silence;
        wr(pda_pkg::OFF_CTRL, cfg(1, 0, 0, 0, 0, 0, 0));
        val(200, 4);
        pulse(4'b0100);
        wr(pda_pkg::OFF_CMD, 1 << pda_pkg::C_SILENCE);
        val(200, 3);
        oc(1'b1);
        wr(pda_pkg::OFF_CTRL, cfg(1, 0, 0, 1, 0, 0, 0));
        pulse(4'b0100);
        oc(1'b0);
        val(0, 4);
        val(200, 4);
        oc(1'b1);
        wr(pda_pkg::OFF_CMD, 1 << pda_pkg::C_SILENCE);
        val(200, 3);
        oc(1'b0);
        val(0, 4);
    endtask

    task automatic t_dev;
        wr(pda_pkg::OFF_HIGH_SP, 50);
        wr(pda_pkg::OFF_LOW_SP, -50);
        wr(pda_pkg::OFF_CTRL, cfg(2, 0, 0, 0, 0, 0, 0));
        want_center <= 18'h003e8;
        val(1051, 4);
        oc(1'b1);
        val(1045, 4);
        oc(1'b1);
        val(949, 4);
        oc(1'b1);
        want_center <= 18'h00384;
        val(935, 4);
        oc(1'b0);
        wr(pda_pkg::OFF_LOW_SP, 20);
        val(915, 4);
        oc(1'b1);
        val(930, 4);
        wr(pda_pkg::OFF_CTRL, cfg(2, 0, 0, 0, 2, 0, 0));
        wr(pda_pkg::OFF_LOW_SP, -50);
        wr(pda_pkg::OFF_HIGH_SP, 20);
        val(1000, 4);
        oc(1'b0);
        val(900, 4);
        val(1000, 4);
        oc(1'b1);
        val(900, 4);
    endtask

    task automatic t_delay;
        wr(pda_pkg::OFF_HIGH_SP, 100);
        wr(pda_pkg::OFF_LOW_SP, -100);
        wr(pda_pkg::OFF_DELAY, 3);
        wr(pda_pkg::OFF_CTRL, cfg(1, 0, 0, 0, 0, 0, 0));
        val(200, 20);
        val(0, 3);
        val(200, 20);
        oc(1'b0);
        val(200, 16);
        oc(1'b1);
        val(0, 4);
        wr(pda_pkg::OFF_DELAY, 0);
    endtask

    task automatic t_off;
        val(200, 4);
        flags <= 4'b0001;
        val(200, 4);
        oc(1'b0);
        flags <= 4'h0;
        val(200, 4);
        oc(1'b1);
        wr(pda_pkg::OFF_CTRL, cfg(0, 0, 0, 0, 0, 0, 1));
        val(0, 4);
        oc(1'b0);
        wr(pda_pkg::OFF_CTRL, cfg(1, 0, 0, 0, 0, 0, 0));
        flags <= 4'b1000;
        val(0, 4);
        oc(1'b1);
        chk("alarm_out_error", alarm_out_error, 0);
        flags <= 4'h0;
        val(0, 4);
        chk("error_seen", error_seen, 0);
    endtask

    // the whole run needs about 350 cycles; a hang is cut short well beyond that
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict;
        end
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_proc;
        t_latch;
        t_silence;
        t_dev;
        t_delay;
        t_off;
        give_verdict;
    end
endmodule

`default_nettype wire

/* File: bench/pda_source.sv */
// upstream signal source and downstream consumer model for the alarm
`timescale 1ns/1ps
`default_nettype none

module pda_source #(
    parameter int DW = 18
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [DW-1:0] want_value,
    input  wire logic [DW-1:0] want_center,
    input  wire logic [3:0]    want_flags,
    input  wire logic          alarm_out_error,
    output var  logic [DW-1:0] monitored_value,
    output var  logic [DW-1:0] center_value,
    output var  logic          monitored_error,
    output var  logic          mute_request,
    output var  logic          acknowledge_reset,
    output var  logic          disable_request,
    output var  logic          error_seen
);
    // ----------------
    // sampled source, one update per clock like a converter chain
    // ----------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            monitored_value <= '0;
            center_value <= '0;
            {monitored_error, mute_request, acknowledge_reset, disable_request} <= 4'h0;
            error_seen <= 1'b0;
        end
        else
        begin
            monitored_value <= want_value;
            center_value <= want_center;
            {monitored_error, mute_request, acknowledge_reset, disable_request} <= want_flags;
            // the consumer never expects an error status on the alarm output
            error_seen <= error_seen | alarm_out_error;
        end
    end
endmodule

`default_nettype wire

/* File: verilog/pda_alarm.sv */
// process / deviation alarm with apb register access
// Functional notes
// RULE_01: sides setting enables high, low or both; unselected side never alarms.
// RULE_02: process alarm clears only past threshold by hysteresis, range 1 to 9999.
// RULE_03: deviation hysteresis measured from the computed trip point.
// RULE_04: silence forces output inactive until alarm clears and recurs.
// RULE_05: mute input or silence command; both ignored when silencing disabled.
// RULE_06: latching alarm needs condition gone plus a clear request.
// RULE_07: non-latching alarm clears by itself once condition with hysteresis ends.
// RULE_08: startup or combined blocking suppresses alarms until value first normal.
// RULE_09: set-point or combined blocking suppresses deviation alarms after threshold change.
// RULE_10: display option raises attention flag while any alarm is active.
// RULE_11: close-on-alarm drives output high on alarm; open-on-alarm inverts.
// RULE_12: trip must hold for delay seconds, 0 to 9999, else restart.
// RULE_13: process high condition is value above high threshold.
// RULE_14: process low condition is value below low threshold.
// RULE_15: clear command resets alarm only once the cause has gone.
// RULE_16: silence command deactivates output, only if silencing enabled.
// RULE_17: deviation high above center plus high offset; low below center plus low offset.
// RULE_18: deviation low trip point is center plus signed low offset.
// RULE_19: disable input acts exactly like alarm type off.
// RULE_20: mute input silences the alarm when silencing enabled.
// RULE_21: with type off the output is held off.
// RULE_22: input error raises the alarm; output error status always none.
// RULE_23: one-second tick paces delay; restart command clears alarms and timers.
// RULE_24: all comparisons in one signed format, evaluated every clock.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module pda_alarm #(
    parameter int DW          = 18,
    parameter int HW          = 14,
    parameter int TICK_CYCLES = pda_pkg::TICK_CYCLES
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    input  wire logic [DW-1:0] monitored_value,
    input  wire logic          monitored_error,
    input  wire logic [DW-1:0] center_value,
    input  wire logic          mute_request,
    input  wire logic          acknowledge_reset,
    input  wire logic          disable_request,
    output var  logic          alarm_out,
    output var  logic          alarm_out_error,
    output var  logic          attention
);
    localparam int EW = DW + 2;

    // ----------------
    // registers
    // ----------------
    logic [pda_pkg::CTRL_W-1:0] ctrl;
    logic [DW-1:0]              high_sp;
    logic [DW-1:0]              low_sp;
    logic [HW-1:0]              hyst;
    logic [HW-1:0]              delay_s;

    // ----------------
    // apb decode
    // ----------------
    wire sel_ctrl   = (paddr == pda_pkg::OFF_CTRL);
    wire sel_high   = (paddr == pda_pkg::OFF_HIGH_SP);
    wire sel_low    = (paddr == pda_pkg::OFF_LOW_SP);
    wire sel_hyst   = (paddr == pda_pkg::OFF_HYST);
    wire sel_delay  = (paddr == pda_pkg::OFF_DELAY);
    wire sel_cmd    = (paddr == pda_pkg::OFF_CMD);
    wire sel_status = (paddr == pda_pkg::OFF_STATUS);
    wire addr_ok    = sel_ctrl | sel_high | sel_low | sel_hyst |
                      sel_delay | sel_cmd | sel_status;
    wire setup_ph   = psel && !penable;
    wire wr_en      = psel && penable && pready && pwrite && addr_ok;

    wire cmd_clear   = wr_en && sel_cmd && pwdata[pda_pkg::C_CLEAR];
    wire cmd_silence = wr_en && sel_cmd && pwdata[pda_pkg::C_SILENCE];
    wire cmd_restart = wr_en && sel_cmd && pwdata[pda_pkg::C_RESTART];

    // hysteresis of zero would let an alarm chatter, so it is held at one
    wire [HW-1:0] hyst_wr = (pwdata[HW-1:0] == '0) ? HW'(1) : pwdata[HW-1:0];

    // ----------------
    // configuration fields
    // ----------------
    pda_pkg::pda_type_t type_cfg;
    pda_pkg::pda_side_t side_cfg;
    pda_pkg::pda_blk_t  blk_cfg;
    assign type_cfg = pda_pkg::pda_type_t'(ctrl[pda_pkg::F_TYPE_LO +: 2]);
    assign side_cfg = pda_pkg::pda_side_t'(ctrl[pda_pkg::F_SIDES_LO +: 2]);
    assign blk_cfg  = pda_pkg::pda_blk_t'(ctrl[pda_pkg::F_BLOCK_LO +: 2]);
    wire latch_en   = ctrl[pda_pkg::F_LATCH];
    wire sil_en     = ctrl[pda_pkg::F_SIL_EN];
    wire display_en = ctrl[pda_pkg::F_DISPLAY];
    wire open_logic = ctrl[pda_pkg::F_LOGIC];

    wire is_proc = (type_cfg == pda_pkg::PDA_TYPE_PROC);
    wire is_dev  = (type_cfg == pda_pkg::PDA_TYPE_DEV);
    wire run     = (is_proc || is_dev) && !disable_request;           // [RULE_19] [RULE_21]
    wire side_h  = (side_cfg == pda_pkg::PDA_SIDE_BOTH) || (side_cfg == pda_pkg::PDA_SIDE_HIGH); // [RULE_01]
    wire side_l  = (side_cfg == pda_pkg::PDA_SIDE_BOTH) || (side_cfg == pda_pkg::PDA_SIDE_LOW);  // [RULE_01]
    wire blk_start = (blk_cfg == pda_pkg::PDA_BLK_START) || (blk_cfg == pda_pkg::PDA_BLK_BOTH);
    wire blk_sp    = (blk_cfg == pda_pkg::PDA_BLK_SP) || (blk_cfg == pda_pkg::PDA_BLK_BOTH);

    // ----------------
    // trip points, all in one widened signed format
    // ----------------
    wire signed [EW-1:0] mon_x  = EW'(signed'(monitored_value));      // [RULE_24]
    wire signed [EW-1:0] ctr_x  = EW'(signed'(center_value));
    wire signed [EW-1:0] hsp_x  = EW'(signed'(high_sp));
    wire signed [EW-1:0] lsp_x  = EW'(signed'(low_sp));
    wire signed [EW-1:0] hys_x  = signed'(EW'(hyst));
    wire signed [EW-1:0] trip_h = is_dev ? ctr_x + hsp_x : hsp_x;     // [RULE_13] [RULE_17]
    wire signed [EW-1:0] trip_l = is_dev ? ctr_x + lsp_x : lsp_x;     // [RULE_14] [RULE_18]

    wire cond_h = run && side_h && (mon_x > trip_h);                  // [RULE_13] [RULE_17]
    wire cond_l = run && side_l && (mon_x < trip_l);                  // [RULE_14] [RULE_17]
    // condition persists until the value is back inside by the hysteresis
    wire hold_h = run && side_h && (mon_x > trip_h - hys_x);          // [RULE_02] [RULE_03]
    wire hold_l = run && side_l && (mon_x < trip_l + hys_x);          // [RULE_02] [RULE_03]
    wire hold_e = run && monitored_error;
    wire normal = run && !cond_h && !cond_l && !monitored_error;

    // ----------------
    // delay qualification
    // ----------------
    logic          high_alarm;
    logic          low_alarm;
    logic          err_alarm;
    logic          silenced;
    logic          start_blk;
    logic          sp_blk;
    logic          tick;
    logic [HW-1:0] sec_cnt;

    wire trip      = (cond_h && !high_alarm) || (cond_l && !low_alarm);
    wire qualified = trip && (sec_cnt >= delay_s);                    // [RULE_12]
    wire blocked   = (blk_start && start_blk) || (blk_sp && is_dev && sp_blk); // [RULE_08] [RULE_09]
    wire clear_req = acknowledge_reset || cmd_clear;                  // [RULE_15]
    wire sil_req   = sil_en && (mute_request || cmd_silence);         // [RULE_05] [RULE_16] [RULE_20]

    pda_tick #(
        .CYCLES  (TICK_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (!trip || cmd_restart),                              // [RULE_23]
        .tick    (tick)
    );

    // counts whole seconds of an unbroken trip, restarting on any gap
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            sec_cnt <= '0;
        else if (!trip || cmd_restart)
            sec_cnt <= '0;                                            // [RULE_12] [RULE_23]
        else if (tick && sec_cnt != '1)
            sec_cnt <= sec_cnt + HW'(1);

    // ----------------
    // alarm state
    // ----------------
    wire set_h = qualified && cond_h && !blocked;
    wire set_l = qualified && cond_l && !blocked;
    wire clr_h = !hold_h && (!latch_en || clear_req);                 // [RULE_06] [RULE_07]
    wire clr_l = !hold_l && (!latch_en || clear_req);                 // [RULE_06] [RULE_07]
    wire clr_e = !hold_e && (!latch_en || clear_req);
    wire kill  = !run || cmd_restart;

    wire next_high_alarm = !kill && (set_h || (high_alarm && !clr_h));
    wire next_low_alarm  = !kill && (set_l || (low_alarm && !clr_l));
    wire next_err_alarm  = !kill && (hold_e || (err_alarm && !clr_e));   // [RULE_22]
    wire alarm_state     = high_alarm || low_alarm || err_alarm;
    wire active          = alarm_state && !silenced;                  // [RULE_04]

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            high_alarm <= 1'b0;
            low_alarm  <= 1'b0;
            err_alarm  <= 1'b0;
        end
        else
        begin
            high_alarm <= next_high_alarm;
            low_alarm  <= next_low_alarm;
            err_alarm  <= next_err_alarm;
        end

    // silence lasts until the alarm state drops, so a recurrence sounds again
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            silenced <= 1'b0;
        else if (!sil_en || !alarm_state || kill)
            silenced <= 1'b0;                                         // [RULE_05]
        else if (sil_req)
            silenced <= 1'b1;                                         // [RULE_04] [RULE_20]

    // blocking flags: startup armed by reset, set point armed by a changed value
    wire sp_change = wr_en && ((sel_high && pwdata[DW-1:0] != high_sp) ||
                               (sel_low && pwdata[DW-1:0] != low_sp));
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            start_blk <= 1'b1;
        else if (normal)
            start_blk <= 1'b0;                                        // [RULE_08]

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            sp_blk <= 1'b0;
        else if (sp_change)
            sp_blk <= 1'b1;                                           // [RULE_09]
        else if (normal)
            sp_blk <= 1'b0;

    // ----------------
    // outputs
    // ----------------
    wire next_alarm_out = run && (open_logic ? !active : active);     // [RULE_11] [RULE_21]

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            alarm_out       <= 1'b0;
            alarm_out_error <= 1'b0;
            attention       <= 1'b0;
        end
        else
        begin
            alarm_out       <= next_alarm_out;
            alarm_out_error <= 1'b0;                                  // [RULE_22]
            attention       <= display_en && alarm_state;             // [RULE_10]
        end

    // ----------------
    // register writes and read path
    // ----------------
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            ctrl    <= pda_pkg::CTRL_RESET;
            high_sp <= '0;
            low_sp  <= '0;
            hyst    <= HW'(pda_pkg::HYST_RESET);
            delay_s <= HW'(pda_pkg::DELAY_RESET);
        end
        else if (wr_en)
        begin
            if (sel_ctrl)
                ctrl <= pwdata[pda_pkg::CTRL_W-1:0];
            if (sel_high)
                high_sp <= pwdata[DW-1:0];
            if (sel_low)
                low_sp <= pwdata[DW-1:0];
            if (sel_hyst)
                hyst <= hyst_wr;
            if (sel_delay)
                delay_s <= pwdata[HW-1:0];
        end

    wire [pda_pkg::S_W-1:0] status_bits = {alarm_out, blocked, silenced,
                                           err_alarm, low_alarm, high_alarm};
    wire [31:0] rd_mux = sel_ctrl   ? 32'(ctrl) :
                         sel_high   ? 32'(signed'(high_sp)) :
                         sel_low    ? 32'(signed'(low_sp)) :
                         sel_hyst   ? 32'(hyst) :
                         sel_delay  ? 32'(delay_s) :
                         sel_status ? 32'(status_bits) : 32'h0000_0000;

    // read data is captured in setup so the access phase needs no wait state
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup_ph;
            pslverr <= setup_ph && !addr_ok;
            if (setup_ph && !pwrite)
                prdata <= rd_mux;
        end

    // ----------------
    // checks
    // ----------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // silence and polarity checks assume ctrl is not rewritten while an alarm stands
    a_side_high_gate: assert property ($rose(high_alarm) // [RULE_01]
        |-> $past(side_h) && $past(cond_h))
        else $error("high alarm rose on an unselected side");
    a_delay_held: assert property ($rose(high_alarm) || $rose(low_alarm) // [RULE_12]
        |-> $past(sec_cnt >= delay_s))
        else $error("alarm declared before the delay expired");
    a_latch_holds: assert property (run && latch_en && high_alarm && !clear_req && !cmd_restart // [RULE_06]
        |=> high_alarm)
        else $error("latched alarm dropped without a clear request");
    a_nonlatch_clear: assert property (run && !latch_en && high_alarm && !hold_h && !disable_request
        |=> !high_alarm) // [RULE_07]
        else $error("non-latching alarm failed to clear");
    a_hyst_keeps: assert property (run && high_alarm && hold_h && !cmd_restart && !disable_request // [RULE_02]
        |=> high_alarm)
        else $error("high alarm cleared inside the hysteresis band");
    a_silence_off: assert property (!sil_en |=> !silenced) // [RULE_05]
        else $error("silence honoured while silencing disabled");
    a_silenced_out: assert property (run && silenced && !disable_request // [RULE_04]
        |=> alarm_out == open_logic)
        else $error("silenced output not at its inactive level");
    a_polarity: assert property (##1 alarm_out == $past(next_alarm_out)) // [RULE_11]
        else $error("alarm output polarity wrong");
    a_disable_off: assert property (disable_request // [RULE_19]
        |=> !alarm_out && !alarm_state)
        else $error("disable did not force the off behaviour");
    a_error_trips: assert property (run && monitored_error && !cmd_restart // [RULE_22]
        |=> err_alarm ##1 alarm_out_error == 1'b0)
        else $error("input error did not raise the alarm");
    a_attention_flag: assert property (##1 attention == $past(display_en && alarm_state)) // [RULE_10]
        else $error("attention flag does not follow the alarm");
    a_block_startup: assert property (blk_start && start_blk && !high_alarm // [RULE_08]
        |=> !high_alarm)
        else $error("alarm raised while startup blocking");
    a_sp_block: assert property (blk_sp && is_dev && sp_blk && !low_alarm // [RULE_09]
        |=> !low_alarm)
        else $error("low alarm raised while set point blocking");
    a_restart_clears: assert property (cmd_restart // [RULE_23]
        |=> !alarm_state && !silenced && sec_cnt == '0)
        else $error("restart left alarm state or timer set");

    c_high_alarm:  cover property ($rose(high_alarm));
    c_low_alarm:   cover property ($rose(low_alarm));
    c_silenced:    cover property ($rose(silenced));
    c_latch_clear: cover property (latch_en && $fell(high_alarm));
    c_restart:     cover property (cmd_restart && alarm_state);

endmodule

`default_nettype wire

/* File: verilog/pda_pkg.sv */
// constants, field layout and encodings of the process/deviation alarm
package pda_pkg;

    // ----------------
    // timing
    // ----------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int TICK_PERIOD_S  = 1;
    localparam int TICK_PERIOD_NS = TICK_PERIOD_S * 1000000000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // ----------------
    // register byte offsets
    // ----------------
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_HIGH_SP = 8'h04;
    localparam logic [7:0] OFF_LOW_SP  = 8'h08;
    localparam logic [7:0] OFF_HYST    = 8'h0c;
    localparam logic [7:0] OFF_DELAY   = 8'h10;
    localparam logic [7:0] OFF_CMD     = 8'h14;
    localparam logic [7:0] OFF_STATUS  = 8'h18;

    // ----------------
    // control register fields
    // ----------------
    localparam int CTRL_W      = 10;
    localparam int F_TYPE_LO   = 0;
    localparam int F_SIDES_LO  = 2;
    localparam int F_LATCH     = 4;
    localparam int F_SIL_EN    = 5;
    localparam int F_BLOCK_LO  = 6;
    localparam int F_DISPLAY   = 8;
    localparam int F_LOGIC     = 9;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

    // command register bits, write one to act
    localparam int C_CLEAR   = 0;
    localparam int C_SILENCE = 1;
    localparam int C_RESTART = 2;

    // status register bits
    localparam int S_HIGH    = 0;
    localparam int S_LOW     = 1;
    localparam int S_ERROR   = 2;
    localparam int S_SILENCE = 3;
    localparam int S_BLOCKED = 4;
    localparam int S_OUT     = 5;
    localparam int S_W       = 6;

    localparam logic [13:0] HYST_RESET  = 14'h0001;
    localparam logic [13:0] DELAY_RESET = 14'h0000;

    // ----------------
    // encodings
    // ----------------
    typedef enum logic [1:0] {
        PDA_TYPE_OFF  = 2'b00,
        PDA_TYPE_PROC = 2'b01,
        PDA_TYPE_DEV  = 2'b10,
        PDA_TYPE_RSV  = 2'b11
    } pda_type_t;

    typedef enum logic [1:0] {
        PDA_SIDE_BOTH = 2'b00,
        PDA_SIDE_HIGH = 2'b01,
        PDA_SIDE_LOW  = 2'b10,
        PDA_SIDE_RSV  = 2'b11
    } pda_side_t;

    typedef enum logic [1:0] {
        PDA_BLK_OFF   = 2'b00,
        PDA_BLK_START = 2'b01,
        PDA_BLK_SP    = 2'b10,
        PDA_BLK_BOTH  = 2'b11
    } pda_blk_t;

endpackage

/* File: verilog/pda_tick.sv */
// restartable divider giving a one-cycle pulse per elapsed second
`timescale 1ns/1ps
`default_nettype none

module pda_tick #(
    parameter int CYCLES = pda_pkg::TICK_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic restart,
    output var  logic tick
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt;
    wire           at_end = (cnt == LAST);

    // restart aligns the first tick a full second after the trip began
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            cnt <= '0;
        else if (restart || at_end)
            cnt <= '0;
        else
            cnt <= cnt + CW'(1);

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            tick <= 1'b0;
        else
            tick <= at_end && !restart;

endmodule

`default_nettype wire
